// file: core/smas_pkg.sv
// Package of constants and types for the supply monitor and ADC sequencer
package smas_pkg;

  // Register indices; byte address is four times the index
  localparam int SMAS_IDX_W = 6;
  localparam logic [5:0] SMAS_IDX_CTRL = 6'h30;
  localparam logic [5:0] SMAS_IDX_GATE_UV_CFG = 6'h31;
  localparam logic [5:0] SMAS_IDX_OSC_TRIM = 6'h32;
  localparam logic [5:0] SMAS_IDX_SELECT_LEN = 6'h33;
  localparam logic [5:0] SMAS_IDX_STATUS = 6'h36;
  localparam logic [5:0] SMAS_IDX_RESULT_BASE = 6'h38;

  // Field positions
  localparam int SMAS_CTRL_EN_BIT = 0;
  localparam int SMAS_CTRL_TARGET_LSB = 8;
  localparam int SMAS_STATUS_UV_BIT = 0;

  // Reset values
  localparam logic SMAS_BOOST_EN_RST = 1'b0;
  localparam logic [6:0] SMAS_BOOST_TARGET_RST = 7'h00;
  localparam logic [2:0] SMAS_GATE_UV_THR_RST = 3'h4;
  localparam logic [4:0] SMAS_OSC_TRIM_RST = 5'h10;

  // Timing: input sampling time of the converter per channel
  localparam int SMAS_CLK_MHZ = 250;
  localparam int SMAS_SAMPLE_NS = 64;
  localparam logic [7:0] SMAS_SAMPLE_CYCLES = 8'((SMAS_SAMPLE_NS * SMAS_CLK_MHZ) / 1000);
  localparam logic [19:0] SMAS_SELECT_LEN_MAX = 20'hfffff;
  localparam logic [3:0] SMAS_ADC_MSB = 4'h8;
  localparam int SMAS_NUM_CH = 5;

  // AXI responses
  localparam logic [1:0] SMAS_RESP_OKAY = 2'h0;
  localparam logic [1:0] SMAS_RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {SMAS_ADC_SAMPLE, SMAS_ADC_CONVERT, SMAS_ADC_STORE} smas_adc_state_t;
  typedef enum logic [2:0] {SMAS_CH_TEMP, SMAS_CH_INTERNAL, SMAS_CH_LOGIC, SMAS_CH_GATE,
    SMAS_CH_BOOST} smas_channel_t;

  // Drive towards the analog converter front end
  typedef struct packed {
    smas_channel_t channel;
    logic sample;
    logic [8:0] dac_code;
  } smas_adc_ctl_t;

  typedef struct packed {
    logic aw_held;
    logic [5:0] aw_idx;
    logic aw_ok;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic boost_en;
    logic [6:0] boost_target;
    logic [2:0] uv_thr;
    logic [4:0] osc_trim;
    logic uv_flag;
    logic boost_on;
    logic sel_prev_n;
    logic [19:0] sel_count;
    logic [19:0] sel_len;
    smas_adc_state_t adc_state;
    smas_channel_t adc_ch;
    logic [7:0] adc_timer;
    logic [3:0] adc_bit;
    logic [8:0] adc_code;
    logic [4:0][8:0] results;
  } smas_state_t;

endpackage : smas_pkg

// file: core/smas_core.sv
// Supply monitor, gate supply lockout, oscillator calibration and ADC sequencer
// Functional notes
// - Booster switches off when gate supply is below the selected lockout threshold.
// - Threshold code zero disables the gate supply lockout entirely.
// - Lockout action sets a sticky flag in the status register at index 0x36.
// - All logic is held in reset until the internal supply passes its threshold.
// - No bus transaction is answered while the internal supply is low.
// - Host writes a 5-bit oscillator trim field that steers the oscillator.
// - Oscillator cycles during a host select pulse are reported in 20 bits.
// - Nine-bit successive approximation gives unsigned results 0 to 511.
// - Sequencer selects each channel, converts and stores without host help.
// - Bus access never stalls conversion; reads return latest completed result.
// - Order: temperature, internal supply, logic supply, gate supply, boost voltage.
// - Logic supply result is nine bits, full scale 6.18 V.
// - Gate supply result is nine bits, full scale 6.18 V.
// - Internal supply result is nine bits, full scale 4.8 V.
// - Boost voltage result is nine bits, full scale 70 V.
// - Temperature result is readable and is also driven out on temperature_result.
// - Seven-bit boost target code sets 9.7 V plus code times 52.3/127 V.
// - After reset the booster is disabled and the target code is zero.
`timescale 1ns/1ps

module smas_core
  import smas_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic internal_supply_ok,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic gate_supply_low,
  input wire logic select_n,
  input wire logic adc_cmp_high,
  output smas_adc_ctl_t adc_ctl,
  output logic booster_enable,
  output logic [6:0] boost_target_code,
  output logic [2:0] gate_supply_uv_threshold,
  output logic [4:0] oscillator_trim,
  output logic [8:0] temperature_result
);

  smas_state_t st_reg;
  smas_state_t st_next;
  logic run;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic do_write;
  logic uv_trip;
  logic [31:0] ctrl_word;
  logic [31:0] wr_word;
  logic [31:0] ctrl_merged;
  logic [5:0] ar_idx;

  // Merge write data into a current register word under the byte strobes
  function automatic logic [31:0] smas_merge(input logic [31:0] old_word,
                                             input logic [31:0] new_word,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_word;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_word[8*i +: 8];
      end
    end
    return res;
  endfunction : smas_merge

  // Valid index test for a mapped register
  function automatic logic smas_mapped(input logic [5:0] idx);
    logic hit;
    hit = (idx == SMAS_IDX_CTRL) || (idx == SMAS_IDX_GATE_UV_CFG) ||
          (idx == SMAS_IDX_OSC_TRIM) || (idx == SMAS_IDX_SELECT_LEN) ||
          (idx == SMAS_IDX_STATUS) ||
          ((idx >= SMAS_IDX_RESULT_BASE) &&
           (idx < SMAS_IDX_RESULT_BASE + 6'(SMAS_NUM_CH)));
    return hit;
  endfunction : smas_mapped

  // Bus slave stays silent until the internal supply is good
  assign run = internal_supply_ok;
  assign s_axi_awready = run && !st_reg.aw_held && !st_reg.bvalid;
  assign s_axi_wready = run && !st_reg.w_held && !st_reg.bvalid;
  assign s_axi_arready = run && !st_reg.rvalid;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign ar_idx = s_axi_araddr[7:2];
  assign do_write = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid;

  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;

  assign adc_ctl.channel = st_reg.adc_ch;
  assign adc_ctl.sample = (st_reg.adc_state == SMAS_ADC_SAMPLE);
  assign adc_ctl.dac_code = st_reg.adc_code;
  assign booster_enable = st_reg.boost_on;
  assign boost_target_code = st_reg.boost_target;
  assign gate_supply_uv_threshold = st_reg.uv_thr;
  assign oscillator_trim = st_reg.osc_trim;
  assign temperature_result = st_reg.results[SMAS_CH_TEMP];

  // Lockout acts only with a non-zero threshold code
  assign uv_trip = (st_reg.uv_thr != 3'h0) && gate_supply_low;

  assign ctrl_word = {17'h0, st_reg.boost_target, 7'h0, st_reg.boost_en};
  assign wr_word = smas_merge(32'h0, st_reg.wdata, st_reg.wstrb);
  // Control word as it will stand after the pending write
  assign ctrl_merged = smas_merge(ctrl_word, st_reg.wdata, st_reg.wstrb);

  always_comb begin
    st_next = st_reg;

    // Write address and data are captured independently
    if (aw_take) begin
      st_next.aw_held = 1'b1;
      st_next.aw_idx = s_axi_awaddr[7:2];
      st_next.aw_ok = (s_axi_awaddr[1:0] == 2'h0);
    end
    if (w_take) begin
      st_next.w_held = 1'b1;
      st_next.wdata = s_axi_wdata;
      st_next.wstrb = s_axi_wstrb;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end

    // Gate supply protection and sticky flag
    st_next.boost_on = st_reg.boost_en && !uv_trip;
    if (do_write) begin
      st_next.aw_held = 1'b0;
      st_next.w_held = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = SMAS_RESP_OKAY;
      if (!st_reg.aw_ok || !smas_mapped(st_reg.aw_idx)) begin
        st_next.bresp = SMAS_RESP_DECERR;
      end else begin
        case (st_reg.aw_idx)
          SMAS_IDX_CTRL: begin
            st_next.boost_en = ctrl_merged[SMAS_CTRL_EN_BIT];
            st_next.boost_target = ctrl_merged[SMAS_CTRL_TARGET_LSB +: 7];
          end
          SMAS_IDX_GATE_UV_CFG: begin
            if (st_reg.wstrb[0]) begin
              st_next.uv_thr = st_reg.wdata[2:0];
            end
          end
          SMAS_IDX_OSC_TRIM: begin
            if (st_reg.wstrb[0]) begin
              st_next.osc_trim = st_reg.wdata[4:0];
            end
          end
          SMAS_IDX_STATUS: begin
            if (wr_word[SMAS_STATUS_UV_BIT]) begin
              st_next.uv_flag = 1'b0;
            end
          end
          default: begin
            st_next.bresp = SMAS_RESP_OKAY;
          end
        endcase
      end
    end
    // Setting wins over a clear in the same cycle
    if (uv_trip) begin
      st_next.uv_flag = 1'b1;
    end

    // Register reads; results are whatever the sequencer last stored
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (ar_take) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = SMAS_RESP_OKAY;
      st_next.rdata = 32'h0;
      if (s_axi_araddr[1:0] != 2'h0 || !smas_mapped(ar_idx)) begin
        st_next.rresp = SMAS_RESP_DECERR;
      end else begin
        case (ar_idx)
          SMAS_IDX_CTRL: begin
            st_next.rdata = ctrl_word;
          end
          SMAS_IDX_GATE_UV_CFG: begin
            st_next.rdata = {29'h0, st_reg.uv_thr};
          end
          SMAS_IDX_OSC_TRIM: begin
            st_next.rdata = {27'h0, st_reg.osc_trim};
          end
          SMAS_IDX_SELECT_LEN: begin
            st_next.rdata = {12'h0, st_reg.sel_len};
          end
          SMAS_IDX_STATUS: begin
            st_next.rdata = {31'h0, st_reg.uv_flag};
          end
          default: begin
            st_next.rdata = {23'h0, st_reg.results[3'(ar_idx - SMAS_IDX_RESULT_BASE)]};
          end
        endcase
      end
    end

    // Count oscillator cycles while the host holds its select pulse low
    st_next.sel_prev_n = select_n;
    if (!select_n) begin
      if (st_reg.sel_prev_n) begin
        st_next.sel_count = 20'h1;
      end else if (st_reg.sel_count != SMAS_SELECT_LEN_MAX) begin
        st_next.sel_count = st_reg.sel_count + 20'h1;
      end
    end else if (!st_reg.sel_prev_n) begin
      st_next.sel_len = st_reg.sel_count;
    end

    // Conversion sequencer runs on its own, untouched by bus traffic
    case (st_reg.adc_state)
      SMAS_ADC_SAMPLE: begin
        if (st_reg.adc_timer == 8'h0) begin
          st_next.adc_state = SMAS_ADC_CONVERT;
          st_next.adc_bit = SMAS_ADC_MSB;
          st_next.adc_code = 9'h100;
        end else begin
          st_next.adc_timer = st_reg.adc_timer - 8'h1;
        end
      end
      SMAS_ADC_CONVERT: begin
        // Keep the trial bit when the input is at or above the trial level
        if (!adc_cmp_high) begin
          st_next.adc_code[st_reg.adc_bit] = 1'b0;
        end
        if (st_reg.adc_bit == 4'h0) begin
          st_next.adc_state = SMAS_ADC_STORE;
        end else begin
          st_next.adc_bit = st_reg.adc_bit - 4'h1;
          st_next.adc_code[st_reg.adc_bit - 4'h1] = 1'b1;
        end
      end
      SMAS_ADC_STORE: begin
        st_next.results[st_reg.adc_ch] = st_reg.adc_code;
        st_next.adc_state = SMAS_ADC_SAMPLE;
        st_next.adc_timer = SMAS_SAMPLE_CYCLES - 8'h1;
        st_next.adc_code = 9'h0;
        if (st_reg.adc_ch == SMAS_CH_BOOST) begin
          st_next.adc_ch = SMAS_CH_TEMP;
        end else begin
          st_next.adc_ch = smas_channel_t'(st_reg.adc_ch + 3'h1);
        end
      end
      default: begin
        st_next.adc_state = SMAS_ADC_SAMPLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !internal_supply_ok) begin
      st_reg <= '0;
      st_reg.boost_en <= SMAS_BOOST_EN_RST;
      st_reg.boost_target <= SMAS_BOOST_TARGET_RST;
      st_reg.uv_thr <= SMAS_GATE_UV_THR_RST;
      st_reg.osc_trim <= SMAS_OSC_TRIM_RST;
      st_reg.sel_prev_n <= 1'b1;
      st_reg.adc_state <= SMAS_ADC_SAMPLE;
      st_reg.adc_ch <= SMAS_CH_TEMP;
      st_reg.adc_timer <= SMAS_SAMPLE_CYCLES - 8'h1;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule : smas_core

// file: tb/smas_assertions.sv
// Port-level checks for the supply monitor and converter sequencer
`timescale 1ns/1ps
module smas_assertions
  import smas_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic internal_supply_ok,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic gate_supply_low,
  input wire smas_adc_ctl_t adc_ctl,
  input wire logic booster_enable,
  input wire logic [6:0] boost_target_code,
  input wire logic [2:0] gate_supply_uv_threshold,
  input wire logic [8:0] temperature_result
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn || !internal_supply_ok);

  a_silent_in_reset: assert property (disable iff (!aresetn) !internal_supply_ok |->
    !s_axi_awready && !s_axi_wready && !s_axi_arready) else $error("ready while in reset");
  a_lockout_off: assert property (gate_supply_low && gate_supply_uv_threshold != 3'h0
    |=> !booster_enable) else $error("booster left on under lockout");
  a_boot_default: assert property (disable iff (1'b0) !aresetn |=>
    !booster_enable && boost_target_code == 7'h00) else $error("bad boot defaults");
  a_channel_order: assert property ($changed(adc_ctl.channel) |-> 3'(adc_ctl.channel) ==
    ($past(adc_ctl.channel) == SMAS_CH_BOOST ? 3'h0 : 3'($past(adc_ctl.channel)) + 3'h1))
    else $error("channel order broken");
  a_sample_time: assert property ($rose(adc_ctl.sample) |-> adc_ctl.sample[*8] ##1
    adc_ctl.sample[*8] ##1 !adc_ctl.sample) else $error("sample phase length");
  a_convert_time: assert property ($fell(adc_ctl.sample) |-> (!adc_ctl.sample)[*8] ##1
    (!adc_ctl.sample)[*2] ##1 adc_ctl.sample) else $error("convert phase length");
  a_temp_source: assert property ($changed(temperature_result) && $past(aresetn) &&
    $past(internal_supply_ok) |-> $past(adc_ctl.channel) == SMAS_CH_TEMP && !$past(adc_ctl.sample))
    else $error("temperature result from wrong slot");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
    $stable(s_axi_rdata)) else $error("read data not held");
endmodule : smas_assertions

bind smas_core smas_assertions smas_assertions_i (.*);

// file: tb/smas_analog_model.sv
// Behavioural converter front end with one held level per channel
`timescale 1ns/1ps
module smas_analog_model
  import smas_pkg::*;
(
  input wire smas_adc_ctl_t adc_ctl,
  input wire logic [4:0][8:0] level,
  output logic adc_cmp_high
);
  // Comparator answers in the same cycle as the trial code
  assign adc_cmp_high = level[adc_ctl.channel] >= adc_ctl.dac_code;
endmodule : smas_analog_model

// file: tb/testbench.sv
// Self-checking bench for the supply monitor and converter sequencer
`timescale 1ns/1ps
module testbench
  import smas_pkg::*;
;
  logic aclk, aresetn, internal_supply_ok, gate_supply_low, select_n, adc_cmp_high;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, booster_enable;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot, gate_supply_uv_threshold;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d, x;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_r;
  smas_adc_ctl_t adc_ctl;
  logic [6:0] boost_target_code;
  logic [4:0] oscillator_trim;
  logic [8:0] temperature_result;
  logic [4:0][8:0] level;
  int num_errors, n_tests, cyc;

  smas_core smas_core_i (.*);
  smas_analog_model smas_analog_model_i (.adc_ctl(adc_ctl), .level(level),
    .adc_cmp_high(adc_cmp_high));

  always #2 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end

  function automatic logic [31:0] ctrl_word(input logic en, input logic [6:0] t);
    return {17'h0, t, 7'h0, en};
  endfunction : ctrl_word

  task automatic report_and_stop();
    $display("errors %0d of %0d checks", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [5:0] i, input logic [31:0] d);
    logic a, w;
    a = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (a || w) begin
      @(posedge aclk);
      if (s_axi_awready) a = 1'b0;
      if (s_axi_wready) w = 1'b0;
      s_axi_awvalid <= a;
      s_axi_wvalid <= w;
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rc(input logic [5:0] i, input logic [31:0] e, input logic [1:0] r = 2'h0);
    s_axi_araddr <= {i, 2'h0};
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd_d = s_axi_rdata;
    rd_r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk(rd_d, e);
    chk(32'(rd_r), 32'(r));
  endtask : rc

  initial begin
    {aclk, aresetn, gate_supply_low, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awprot, s_axi_arprot, level} = '0;
    {internal_supply_ok, select_n, s_axi_wstrb} = 6'h3f;
    x = $urandom(50);
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    internal_supply_ok <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(32'({s_axi_awready, s_axi_wready, s_axi_arready}), 32'h0);
    internal_supply_ok <= 1'b1;
    rc(SMAS_IDX_CTRL, 32'h0);
    chk(32'(booster_enable), 32'h0);
    rc(SMAS_IDX_GATE_UV_CFG, 32'(SMAS_GATE_UV_THR_RST));
    rc(SMAS_IDX_OSC_TRIM, 32'(SMAS_OSC_TRIM_RST));
    for (int k = 0; k < 3; k++) begin
      x = $urandom;
      wr(SMAS_IDX_OSC_TRIM, x);
      rc(SMAS_IDX_OSC_TRIM, 32'(x[4:0]));
      chk(32'(oscillator_trim), 32'(x[4:0]));
      x = (k == 0) ? 32'h7f : $urandom;
      wr(SMAS_IDX_CTRL, ctrl_word(1'b1, x[6:0]));
      rc(SMAS_IDX_CTRL, ctrl_word(1'b1, x[6:0]));
      chk(32'(boost_target_code), 32'(x[6:0]));
    end
    for (int k = 0; k < 2; k++) begin
      x = (k == 0) ? 32'h0 : 32'($urandom_range(7, 1));
      wr(SMAS_IDX_GATE_UV_CFG, x);
      chk(32'(gate_supply_uv_threshold), 32'(x[2:0]));
      gate_supply_low <= 1'b1;
      repeat (3) @(posedge aclk);
      chk(32'(booster_enable), 32'(x == 0));
      gate_supply_low <= 1'b0;
      repeat (3) @(posedge aclk);
      rc(SMAS_IDX_STATUS, 32'(x != 0));
      wr(SMAS_IDX_STATUS, 32'h1);
      rc(SMAS_IDX_STATUS, 32'h0);
    end
    for (int k = 0; k < 2; k++) begin
      x = (k == 0) ? 32'h1 : 32'($urandom_range(200, 2));
      select_n <= 1'b0;
      repeat (x) @(posedge aclk);
      select_n <= 1'b1;
      repeat (2) @(posedge aclk);
      rc(SMAS_IDX_SELECT_LEN, x);
    end
    level <= {9'($urandom), 9'($urandom), 9'($urandom), 9'h000, 9'h1ff};
    repeat (140) @(posedge aclk);
    // Bus traffic while the sequencer runs
    for (int k = 0; k < 4; k++) rc(SMAS_IDX_RESULT_BASE, 32'(level[0]));
    repeat (150) @(posedge aclk);
    for (int k = 0; k < SMAS_NUM_CH; k++)
      rc(SMAS_IDX_RESULT_BASE + 6'(k), 32'(level[k]));
    chk(32'(temperature_result), 32'(level[0]));
    rc(6'h3f, 32'h0, SMAS_RESP_DECERR);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(32'({booster_enable, boost_target_code}), 32'h0);
    rc(SMAS_IDX_CTRL, 32'h0);
    report_and_stop();
  end
endmodule : testbench
